// ==== verilog/iocd_defines.svh ====
// Register offsets, field positions, reset values and command codes of the decoder
`ifndef IOCD_DEFINES_SVH
`define IOCD_DEFINES_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define IOCD_ADDR_CMD    8'h00
`define IOCD_ADDR_CFG    8'h04
`define IOCD_ADDR_STAT   8'h08
`define IOCD_ADDR_PWR    8'h0c

// ************************************************************
// Field positions
// ************************************************************
`define IOCD_CC_MSB      15
`define IOCD_CC_LSB      8
`define IOCD_CFG_GW_BIT  0
`define IOCD_CFG_GWF_BIT 1
`define IOCD_CFG_HLF_BIT 2
`define IOCD_INEN_LSB    8
`define IOCD_NODE_LSB    8
`define IOCD_PWR_STRIDE  8

// ************************************************************
// Reset values
// ************************************************************
`define IOCD_CFG_RST     3'h0
`define IOCD_INEN_RST    6'h3f

// ************************************************************
// Control codes and data field encodings
// ************************************************************
`define IOCD_CC_BASELINE 8'h10
`define IOCD_CC_GW_FAIL  8'h11
`define IOCD_CC_HOST_TO  8'h12
`define IOCD_CC_SAMPLE   8'h13
`define IOCD_CC_SURVEY   8'h20
`define IOCD_CC_PWR_ALL  8'h30
`define IOCD_CC_PWR_1    8'h31
`define IOCD_CC_PWR_4    8'h34
`define IOCD_NODE_MAX    8'h38
`define IOCD_V_OFF       8'h00
`define IOCD_V_5         8'h05
`define IOCD_V_7         8'h07
`define IOCD_V_15        8'h0f
`define IOCD_V_20        8'h14
`define IOCD_V_24        8'h18

`endif

// ==== verilog/iocd_pkg.sv ====
// Types shared by the control command decoder
package iocd_pkg;

  // ************************************************************
  // Complete state of the decoder
  // ************************************************************
  typedef struct packed {
    logic [15:0] cmd;          // Last command word written
    logic        cfg_gw;       // Unit acts as the gateway
    logic        cfg_gwf_en;   // Gateway link failure enable
    logic        cfg_hlf_en;   // Host link failure enable
    logic [5:0]  in_en;        // Enabled input points 1..6
    logic [5:0]  gw_dflt;      // One-cycle default request, points 9..14
    logic        host_dflt;    // One-cycle default request, all outputs
    logic [5:0]  sample;       // One-cycle sample request, points 1..6
    logic        baseline;     // One-cycle baseline start
    logic        survey_act;   // Site survey running
    logic [5:0]  survey_node;  // Node in the survey
    logic        err_rep;      // Error report after suppression
    logic [3:0]  pwr_en;       // Switched power enables
    logic [19:0] pwr_volt;     // Four 5-bit voltage codes
    logic [31:0] rdata;        // Read data, one cycle after the strobe
  } iocd_state_t;

endpackage : iocd_pkg

// ==== verilog/iocd_decoder.sv ====
// Control command decoder with register port and decoded action outputs
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "iocd_defines.svh"

module iocd_decoder #(
  parameter int NUM_INPUTS = 6
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic        err_in,
  output logic      [31:0] rdata_out,
  output logic      [5:0]  gw_default_out,
  output logic             host_default_out,
  output logic      [5:0]  sample_req_out,
  output logic             baseline_out,
  output logic             survey_active_out,
  output logic      [5:0]  survey_node_out,
  output logic             err_report_out,
  output logic      [3:0]  pwr_en_out,
  output logic      [19:0] pwr_volt_out
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (NUM_INPUTS != 6)
  begin : g_bad_inputs
    $error("iocd_decoder serves exactly six input points");
  end

  // ************************************************************
  // Decode helpers
  // ************************************************************
  // Only the six printed voltage encodings are legal
  function automatic logic volt_ok(input logic [7:0] d);
    volt_ok = (d == `IOCD_V_OFF) || (d == `IOCD_V_5) || (d == `IOCD_V_7) ||
              (d == `IOCD_V_15) || (d == `IOCD_V_20) || (d == `IOCD_V_24);
  endfunction : volt_ok

  iocd_pkg::iocd_state_t s_q;
  iocd_pkg::iocd_state_t s_d;

  logic       cmd_wr;
  logic [7:0] cc;
  logic [7:0] dat;

  // Command write and its two bytes
  // code and data split
  assign cmd_wr = wr_in && (addr_in == `IOCD_ADDR_CMD);
  assign cc     = wdata_in[`IOCD_CC_MSB:`IOCD_CC_LSB];
  assign dat    = wdata_in[7:0];

  // ************************************************************
  // Next state
  // ************************************************************
  // Pulses fall back to zero unless a command raises them this cycle
  always_comb
  begin
    s_d           = s_q;
    s_d.gw_dflt   = 6'h00;
    s_d.host_dflt = 1'b0;
    s_d.sample    = 6'h00;
    s_d.baseline  = 1'b0;
    s_d.rdata     = 32'h0000_0000;
    s_d.err_rep   = err_in && !s_q.survey_act;

    // Configuration writes
    if (wr_in && (addr_in == `IOCD_ADDR_CFG))
    begin
      s_d.cfg_gw     = wdata_in[`IOCD_CFG_GW_BIT];
      s_d.cfg_gwf_en = wdata_in[`IOCD_CFG_GWF_BIT];
      s_d.cfg_hlf_en = wdata_in[`IOCD_CFG_HLF_BIT];
      s_d.in_en      = wdata_in[`IOCD_INEN_LSB +: 6];
    end

    // Command decode; the word is always kept in cmd, anything not matched below changes nothing else
    if (cmd_wr)
    begin
      s_d.cmd = wdata_in[15:0];
      case (cc)
        `IOCD_CC_BASELINE:
        begin
          if (dat == 8'h00)
            s_d.baseline = 1'b1;
        end
        `IOCD_CC_GW_FAIL:
        begin
          if (s_q.cfg_gwf_en)
            s_d.gw_dflt = dat[5:0];
        end
        `IOCD_CC_HOST_TO:
        begin
          if (s_q.cfg_hlf_en && (dat == 8'h00))
            s_d.host_dflt = 1'b1;
        end
        `IOCD_CC_SAMPLE:
        begin
          s_d.sample = dat[5:0] & s_q.in_en;
        end
        `IOCD_CC_SURVEY:
        begin
          if (s_q.cfg_gw)
          begin
            if (dat == 8'h00)
            begin
              s_d.survey_act  = 1'b0;
              s_d.survey_node = 6'h00;
            end
            else if ((dat <= `IOCD_NODE_MAX) &&
                     (!s_q.survey_act || (s_q.survey_node == dat[5:0])))
            begin
              s_d.survey_act  = 1'b1;
              s_d.survey_node = dat[5:0];
            end
          end
        end
        default:
        begin
          // A bad voltage code drops the whole command, so no rail sees half a setting
          // switched power voltage
          if ((cc >= `IOCD_CC_PWR_ALL) && (cc <= `IOCD_CC_PWR_4) && volt_ok(dat))
          begin
            for (int i = 0; i < 4; i++)
            begin
              if ((cc == `IOCD_CC_PWR_ALL) || (cc == (`IOCD_CC_PWR_1 + 8'(i))))
              begin
                s_d.pwr_en[i]         = (dat != `IOCD_V_OFF);
                s_d.pwr_volt[5*i +: 5] = dat[4:0];
              end
            end
          end
        end
      endcase
    end

    // Reads have no side effects, so a polling host never disturbs a survey
    // Read answers; unmapped addresses read zero
    if (rd_in)
    begin
      if (addr_in == `IOCD_ADDR_CMD)
        s_d.rdata = {16'h0000, s_q.cmd};
      else if (addr_in == `IOCD_ADDR_CFG)
        s_d.rdata = {18'h00000, s_q.in_en, 5'h00, s_q.cfg_hlf_en,
                     s_q.cfg_gwf_en, s_q.cfg_gw};
      else if (addr_in == `IOCD_ADDR_STAT)
        s_d.rdata = {18'h00000, s_q.survey_node, 7'h00, s_q.survey_act};
      else if (addr_in == `IOCD_ADDR_PWR)
      begin
        for (int i = 0; i < 4; i++)
          s_d.rdata[`IOCD_PWR_STRIDE*i +: 8] = {3'h0, s_q.pwr_volt[5*i +: 5]};
      end
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_q            <= '0;
      s_q.in_en      <= `IOCD_INEN_RST;
      {s_q.cfg_hlf_en, s_q.cfg_gwf_en, s_q.cfg_gw} <= `IOCD_CFG_RST;
    end
    else
      s_q <= s_d;
  end

  // Outputs come straight from the state flops
  assign rdata_out         = s_q.rdata;
  assign gw_default_out    = s_q.gw_dflt;
  assign host_default_out  = s_q.host_dflt;
  assign sample_req_out    = s_q.sample;
  assign baseline_out      = s_q.baseline;
  assign survey_active_out = s_q.survey_act;
  assign survey_node_out   = s_q.survey_node;
  assign err_report_out    = s_q.err_rep;
  assign pwr_en_out        = s_q.pwr_en;
  assign pwr_volt_out      = s_q.pwr_volt;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Checks look one edge after the strobe, where the registered outputs show it
  // Back-to-back strobes are legal, so no pulse check may assume an idle cycle

  gw_fail_a: assert property (
    cmd_wr && (cc == `IOCD_CC_GW_FAIL) && s_q.cfg_gwf_en
      |=> gw_default_out == $past(wdata_in[5:0]))
    else $error("gateway failure mask not applied");

  gw_gate_a: assert property (
    !(cmd_wr && (cc == `IOCD_CC_GW_FAIL) && s_q.cfg_gwf_en)
      |=> gw_default_out == 6'h00)
    else $error("output default without enabled command");

  host_to_a: assert property (
    cmd_wr && (wdata_in[15:0] == 16'h1200) && s_q.cfg_hlf_en
      |=> host_default_out ##1 (!host_default_out || $past(cmd_wr)))
    else $error("host timeout default not a single pulse");

  host_gate_a: assert property (
    host_default_out |-> $past(s_q.cfg_hlf_en && cmd_wr))
    else $error("host default while disabled");

  sample_mask_a: assert property (
    cmd_wr && (cc == `IOCD_CC_SAMPLE)
      |=> sample_req_out == ($past(wdata_in[5:0]) & $past(s_q.in_en)))
    else $error("sample request mask wrong");

  survey_range_a: assert property (
    survey_active_out |-> (survey_node_out != 6'h00) && (survey_node_out <= 6'h38))
    else $error("survey node out of range");

  err_mute_a: assert property (
    survey_active_out |=> !err_report_out)
    else $error("error reported during survey");

  survey_one_a: assert property (
    survey_active_out && $past(survey_active_out) |-> $stable(survey_node_out))
    else $error("survey node changed while running");

  survey_off_a: assert property (
    cmd_wr && (wdata_in[15:0] == 16'h2000) && s_q.cfg_gw |=> !survey_active_out)
    else $error("survey not disabled by node zero");

  pwr_all_a: assert property (
    cmd_wr && (cc == `IOCD_CC_PWR_ALL) && volt_ok(dat)
      |=> pwr_en_out == {4{$past(dat) != 8'h00}})
    else $error("all switched outputs not set");

  baseline_a: assert property (
    baseline_out |-> $past(cmd_wr && (wdata_in[15:0] == 16'h1000)))
    else $error("baseline without its command");

  nongw_a: assert property (
    cmd_wr && (cc == `IOCD_CC_SURVEY) && !s_q.cfg_gw |=> $stable(survey_active_out))
    else $error("survey changed on a non-gateway unit");

  sample_all_a: assert property (
    cmd_wr && (wdata_in[15:0] == 16'h133f) && (s_q.in_en == 6'h3f)
      |=> sample_req_out == 6'h3f)
    else $error("full sample mask not honoured");

  baseline_go_a: assert property (
    cmd_wr && (wdata_in[15:0] == 16'h1000) |=> baseline_out)
    else $error("baseline command not started");

  unknown_a: assert property (
    cmd_wr && (cc > `IOCD_CC_PWR_4)
      |=> $stable(pwr_en_out) && $stable(pwr_volt_out) && $stable(survey_active_out) &&
          $stable(survey_node_out) && (gw_default_out == 6'h00) && !host_default_out &&
          (sample_req_out == 6'h00) && !baseline_out)
    else $error("unknown code changed state");

  for (genvar g = 0; g < 4; g++)
  begin : g_pwr_chk
    pwr_one_a: assert property (
      cmd_wr && (cc == (`IOCD_CC_PWR_1 + 8'(g))) && volt_ok(dat)
        |=> (pwr_en_out[g] == ($past(dat) != 8'h00)) &&
            (pwr_volt_out[5*g +: 5] == $past(dat[4:0])))
      else $error("single switched output not set");
  end

  survey_run_c: cover property (cmd_wr && (cc == `IOCD_CC_SURVEY) ##1 survey_active_out);
  sample_all_c: cover property (sample_req_out == 6'h3f);
  pwr_one_c:    cover property (cmd_wr && (cc == `IOCD_CC_PWR_1 + 8'h02) ##1 pwr_en_out[2]);
  host_to_c:    cover property (host_default_out);
  err_mute_c:   cover property (survey_active_out && err_in ##1 !err_report_out);

endmodule : iocd_decoder

// ==== verif/iocd_host_model.sv ====
// Host bus master model that writes and reads the decoder registers
`timescale 1ns/1ps
// ************************************************************
// Host register bus master
// ************************************************************
module iocd_host_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] rdata_in,
  output logic      [7:0]  addr_out,
  output logic      [31:0] wdata_out,
  output logic             wr_out,
  output logic             rd_out
);
  // Idle bus at time zero
  initial
  begin
    addr_out  = 8'h00;
    wdata_out = 32'h0000_0000;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // Whole word to the register at address a
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    // Released bus shows junk, so a stale value never looks valid
    addr_out  <= ~a;
    wdata_out <= ~d;
    #1;
  endtask : wr_reg

  // Read data are taken in the one cycle they stand
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
  endtask : rd_reg
endmodule : iocd_host_model

// ==== verif/tb_top.sv ====
// Self-checking bench for the control command decoder
`timescale 1ns/1ps
`include "iocd_defines.svh"
// ************************************************************
// Bench top
// ************************************************************
module tb_top;
  logic        ref_clk_in = 1'b0;
  logic        rst_b_in   = 1'b0;
  logic        err_in     = 1'b0;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic        wr;
  logic        rd;
  logic [5:0]  gw_dflt;
  logic [5:0]  sample;
  logic [5:0]  node;
  logic        host_dflt;
  logic        baseline;
  logic        surv;
  logic        err_rep;
  logic [3:0]  pwr_en;
  logic [19:0] volt;
  int          error_cnt = 0;
  int          n_checks  = 0;
  localparam logic [7:0] VC [6] = '{`IOCD_V_OFF, `IOCD_V_5, `IOCD_V_7,
                                    `IOCD_V_15, `IOCD_V_20, `IOCD_V_24};

  // Clock of 25 ns period
  always #12.5 ref_clk_in = ~ref_clk_in;

  iocd_decoder #(.NUM_INPUTS(6)) uut (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .err_in(err_in),
    .rdata_out(rdata), .gw_default_out(gw_dflt), .host_default_out(host_dflt),
    .sample_req_out(sample), .baseline_out(baseline),
    .survey_active_out(surv), .survey_node_out(node),
    .err_report_out(err_rep), .pwr_en_out(pwr_en), .pwr_volt_out(volt));

  iocd_host_model host (
    .clk_in(ref_clk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wc(input logic [31:0] d);
    host.wr_reg(`IOCD_ADDR_CMD, d);
  endtask : wc

  task automatic cf(input logic [31:0] d);
    host.wr_reg(`IOCD_ADDR_CFG, d);
  endtask : cf

  // One error event; report expected only outside a survey
  task automatic t_err(input logic exp);
    @(posedge ref_clk_in);
    err_in <= 1'b1;
    @(posedge ref_clk_in);
    err_in <= 1'b0;
    #1;
    chk(32'(err_rep), 32'(exp));
  endtask : t_err

  // Config reset value, unmapped read, read data for one cycle only
  task automatic t_regs();
    host.rd_reg(`IOCD_ADDR_CFG, rv);
    chk(rv, 32'h0000_3f00);
    host.rd_reg(8'h10, rv);
    chk(rv, 32'h0);
    @(posedge ref_clk_in);
    #1;
    chk(rdata, 32'h0);
    $display("done regs");
  endtask : t_regs

  // Forced sample, input enables, one-cycle pulse
  task automatic t_sample();
    wc(32'h0000_133f);
    chk(32'(sample), 32'h3f);
    @(posedge ref_clk_in);
    #1;
    chk(32'(sample), 32'h0);
    cf(32'h0000_0500);
    wc(32'hffff_1307);
    chk(32'(sample), 32'h05);
    host.rd_reg(`IOCD_ADDR_CMD, rv);
    chk(rv, 32'h0000_1307);
    $display("done sample");
  endtask : t_sample

  // Defaulting commands gated by their enables, and baseline
  task automatic t_dflt();
    cf(32'h0000_3f00);
    wc(32'h0000_112a);
    chk(32'(gw_dflt), 32'h0);
    wc(32'h0000_1200);
    chk(32'(host_dflt), 32'h0);
    cf(32'h0000_3f06);
    wc(32'h0000_112a);
    chk(32'(gw_dflt), 32'h2a);
    wc(32'h0000_113f);
    chk(32'(gw_dflt), 32'h3f);
    wc(32'h0000_1200);
    chk(32'(host_dflt), 32'h1);
    wc(32'h0000_1201);
    chk(32'(host_dflt), 32'h0);
    wc(32'h0000_1000);
    chk(32'(baseline), 32'h1);
    wc(32'h0000_1001);
    chk(32'(baseline), 32'h0);
    $display("done defaults");
  endtask : t_dflt

  // Survey role, range, exclusivity, error suppression
  task automatic t_survey();
    cf(32'h0000_3f00);
    wc(32'h0000_2005);
    chk(32'(surv), 32'h0);
    cf(32'h0000_3f01);
    wc(32'h0000_2038);
    chk(32'({surv, node}), 32'h78);
    t_err(1'b0);
    // Host breaks the order on purpose here
    wc(32'h0000_2003);
    chk(32'({surv, node}), 32'h78);
    host.rd_reg(`IOCD_ADDR_STAT, rv);
    chk(rv, 32'h0000_3801);
    wc(32'h0000_2000);
    chk(32'({surv, node}), 32'h0);
    // Out-of-range node while idle, so only the range check can refuse it
    wc(32'h0000_2039);
    chk(32'({surv, node}), 32'h0);
    t_err(1'b1);
    // Host keeps the order: disabled first, then the next node
    wc(32'h0000_2003);
    chk(32'({surv, node}), 32'h43);
    $display("done survey");
  endtask : t_survey

  // Every voltage code on all outputs, then each output alone
  task automatic t_power();
    for (int i = 0; i < 6; i++)
    begin
      wc({24'h30, VC[i]});
      chk(32'(pwr_en), (i == 0) ? 32'h0 : 32'hf);
      chk(32'(volt), 32'({4{VC[i][4:0]}}));
    end
    for (int i = 0; i < 4; i++)
    begin
      wc({16'h0, 8'(`IOCD_CC_PWR_1 + i), VC[i + 1]});
    end
    chk(32'(volt), 32'({5'h14, 5'h0f, 5'h07, 5'h05}));
    host.rd_reg(`IOCD_ADDR_PWR, rv);
    chk(rv, 32'h140f_0705);
    wc(32'h0000_3006);
    wc(32'h0000_4018);
    chk(32'(volt), 32'({5'h14, 5'h0f, 5'h07, 5'h05}));
    wc(32'h0000_3300);
    chk(32'(pwr_en), 32'hb);
    $display("done power");
  endtask : t_power

  // Mid-run reset clears survey, power and configuration
  task automatic t_reset();
    @(posedge ref_clk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1;
    chk(32'({surv, node}), 32'h0);
    chk(32'(pwr_en), 32'h0);
    chk(32'(volt), 32'h0);
    @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    host.rd_reg(`IOCD_ADDR_CFG, rv);
    chk(rv, 32'h0000_3f00);
    host.rd_reg(`IOCD_ADDR_PWR, rv);
    chk(rv, 32'h0);
    $display("done reset");
  endtask : t_reset

  // Counts, verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Main sequence after 12 cycles of reset
  initial
  begin
    repeat (12) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    t_regs();
    t_sample();
    t_dflt();
    t_survey();
    t_power();
    t_reset();
    tally_and_finish();
  end

  // Watchdog so a hang still ends in the verdict
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    error_cnt++;
    tally_and_finish();
  end
endmodule : tb_top
